/* verilog/alu_params.svh */
`ifndef ALU_PARAMS_SVH
`define ALU_PARAMS_SVH

// ---------------------------------------------------------------
// Widths
// ---------------------------------------------------------------
`define ALU_ACC_W 4
`define ALU_WORD_W 10
`define ALU_PAGE_W 2
`define ALU_ADDR_W 10
`define ALU_SLOTS 8
`define ALU_PINS_W 32

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define ALU_ACC_MSB 3
`define ALU_HI_NIB_MSB 7
`define ALU_HI_NIB_LSB 4
`define ALU_LO_NIB_MSB 3
`define ALU_LO_NIB_LSB 0
`define ALU_IMM_MSB 3
`define ALU_IMM_LSB 0

// ---------------------------------------------------------------
// Reset values and nibble constants
// ---------------------------------------------------------------
`define ALU_ACC_RST 4'h0
`define ALU_CARRY_RST 1'b0
`define ALU_LATCH_RST 4'h0
`define ALU_ZERO_NIB 4'h0
`define ALU_ONE_NIB 4'h1

// ---------------------------------------------------------------
// Valid port indices and their slots within a group
// ---------------------------------------------------------------
`define ALU_PIDX_0 3'h0
`define ALU_PIDX_1 3'h1
`define ALU_PIDX_3 3'h3
`define ALU_PIDX_4 3'h4
`define ALU_SLOT_0 2'h0
`define ALU_SLOT_1 2'h1
`define ALU_SLOT_3 2'h2
`define ALU_SLOT_4 2'h3

`endif

/* verilog/alu_pkg.sv */
`include "alu_params.svh"

package alu_pkg;

   // Operation requested by the sequencer
   typedef enum logic [3:0] {
      ALU_OP_NONE     = 4'h0,
      ALU_OP_AND_REG  = 4'h1,
      ALU_OP_AND_ROM  = 4'h2,
      ALU_OP_AND_IMM  = 4'h3,
      ALU_OP_OR_REG   = 4'h4,
      ALU_OP_OR_ROM   = 4'h5,
      ALU_OP_OR_IMM   = 4'h6,
      ALU_OP_XOR_REG  = 4'h7,
      ALU_OP_XOR_ROM  = 4'h8,
      ALU_OP_XOR_IMM  = 4'h9,
      ALU_OP_INC      = 4'hA,
      ALU_OP_ROT      = 4'hB,
      ALU_OP_ROT_ZRST = 4'hC,
      ALU_OP_PORT_WR  = 4'hD,
      ALU_OP_PORT_RD  = 4'hE
   } alu_op_e;

   // Function of the logic slice
   typedef enum logic [2:0] {
      ALU_K_AND  = 3'h0,
      ALU_K_OR   = 3'h1,
      ALU_K_XOR  = 3'h2,
      ALU_K_INC  = 3'h3,
      ALU_K_ROT  = 3'h4,
      ALU_K_PASS = 3'h5,
      ALU_K_HOLD = 3'h6
   } alu_kind_e;

   typedef enum logic {
      ALU_ST_IDLE = 1'b0,
      ALU_ST_IMM  = 1'b1
   } alu_state_e;

   typedef logic [`ALU_ACC_W-1:0] alu_nib_t;

endpackage : alu_pkg

/* verilog/alu_logic.sv */
`timescale 1ns/10ps
`include "alu_params.svh"

module alu_logic
   import alu_pkg::*;
(
   input wire alu_kind_e i_kind,   // Function select
   input wire alu_nib_t i_acc,     // Accumulator now
   input wire alu_nib_t i_operand, // Second operand
   input wire logic i_carry,       // Carry now
   output alu_nib_t o_result,      // New accumulator
   output logic o_carry            // New carry
);

   alu_nib_t inc_sum;

   // [RULE17] Four-bit wrap
   assign inc_sum = i_acc + `ALU_ONE_NIB;

   always_comb begin
      o_result = i_acc;
      o_carry = i_carry;
      unique case (i_kind)
         ALU_K_AND: begin
            // [RULE1] And with carry
            o_result = i_acc & i_operand;
            o_carry = i_acc[`ALU_ACC_MSB] & i_operand[`ALU_ACC_MSB];
         end
         ALU_K_OR: begin
            // [RULE6] Or clears carry
            o_result = i_acc | i_operand;
            o_carry = 1'b0;
         end
         ALU_K_XOR: begin
            // [RULE9] Xor, and-carry
            o_result = i_acc ^ i_operand;
            o_carry = i_acc[`ALU_ACC_MSB] & i_operand[`ALU_ACC_MSB];
         end
         ALU_K_INC: begin
            // [RULE12] Carry on zero
            o_result = inc_sum;
            o_carry = (inc_sum == `ALU_ZERO_NIB);
         end
         ALU_K_ROT: begin
            // [RULE13] Rotate through top
            o_result = {i_acc[`ALU_ACC_MSB-1:0], i_acc[`ALU_ACC_MSB]};
            o_carry = i_acc[`ALU_ACC_MSB];
         end
         ALU_K_PASS: begin
            // Port read leaves carry alone
            o_result = i_operand;
         end
         ALU_K_HOLD: begin
            o_result = i_acc;
         end
         default: begin
            o_result = i_acc;
         end
      endcase
   end

endmodule : alu_logic

/* verilog/alu_core.sv */
`timescale 1ns/10ps
`include "alu_params.svh"

// Overview of operation
// [RULE1] And register into accumulator, carry A3&R3
// [RULE2] And ROM nibble, carry from bit 7/3
// [RULE3] ROM address from page and R1_0:R0_0
// [RULE4] High nibble b7-b4, low b3-b0
// [RULE5] Two-word and immediate, carry A3&d3
// [RULE6] Or register, carry cleared
// [RULE7] Or ROM nibble, carry cleared
// [RULE8] Or immediate, carry cleared
// [RULE9] Xor register, carry A3&R3
// [RULE10] Xor ROM nibble, carry from bit 7/3
// [RULE11] Xor immediate, carry A3&d3
// [RULE12] Increment, carry set on zero result
// [RULE13] Rotate left, old bit 3 to carry
// [RULE14] Zero rotate resets when accumulator zero
// [RULE15] Port write latches accumulator, indices 0,1,3,4
// [RULE16] Port read loads port nibble
// [RULE17] Increment of fifteen wraps to zero

module alu_core
   import alu_pkg::*;
(
   input wire logic i_core_clk,                   // Core clock
   input wire logic i_sys_rst,                    // Sync reset, high
   input wire logic i_op_valid,                   // Operation offered
   input wire alu_op_e i_op,                      // Operation code
   input wire logic i_nib_high,                   // ROM high nibble sel
   input wire alu_nib_t i_reg_data,               // General register
   input wire logic i_word_valid,                 // Second word valid
   input wire logic [`ALU_WORD_W-1:0] i_word,     // Second word
   input wire logic [`ALU_WORD_W-1:0] i_rom_word, // Addressed ROM word
   input wire logic [`ALU_PAGE_W-1:0] i_page_ctrl, // ROM page control
   input wire alu_nib_t i_pair_r1,                // Pointer high nibble
   input wire alu_nib_t i_pair_r0,                // Pointer low nibble
   input wire logic i_port_grp,                   // Port group select
   input wire logic [2:0] i_port_idx,             // Port index
   input wire logic [`ALU_PINS_W-1:0] i_port_pins, // Port pin levels
   output logic o_ready,                          // Can take operation
   output logic [`ALU_ADDR_W-1:0] o_rom_addr,     // ROM operand address
   output alu_nib_t o_acc,                        // Accumulator
   output logic o_carry,                          // Carry flag
   output logic o_int_reset,                      // Internal reset pulse
   output logic [`ALU_PINS_W-1:0] o_port_latch,   // Port output latches
   output logic o_port_bad,                       // Bad port index pulse
   output logic o_done                            // Operation done pulse
);

   // ---------------------------------------------------------------
   // Decode helpers
   // ---------------------------------------------------------------

   // [RULE4] Nibble field select
   function automatic alu_nib_t rom_nib(
      input logic [`ALU_WORD_W-1:0] word,
      input logic high
   );
      if (high) begin
         rom_nib = word[`ALU_HI_NIB_MSB:`ALU_HI_NIB_LSB];
      end else begin
         rom_nib = word[`ALU_LO_NIB_MSB:`ALU_LO_NIB_LSB];
      end
   endfunction : rom_nib

   // [RULE15] Valid index map
   function automatic logic [3:0] port_slot(
      input logic grp,
      input logic [2:0] idx
   );
      logic [1:0] pos;
      logic ok;
      pos = 2'h0;
      ok = 1'b1;
      unique case (idx)
         `ALU_PIDX_0: pos = `ALU_SLOT_0;
         `ALU_PIDX_1: pos = `ALU_SLOT_1;
         `ALU_PIDX_3: pos = `ALU_SLOT_3;
         `ALU_PIDX_4: pos = `ALU_SLOT_4;
         default: ok = 1'b0;
      endcase
      port_slot = {ok, grp, pos};
   endfunction : port_slot

   function automatic logic is_imm(input alu_op_e op);
      is_imm = (op == ALU_OP_AND_IMM) || (op == ALU_OP_OR_IMM) ||
         (op == ALU_OP_XOR_IMM);
   endfunction : is_imm

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   alu_state_e state_reg;
   alu_state_e state_next;
   alu_op_e pend_op_reg;
   alu_nib_t acc_reg;
   alu_nib_t acc_next;
   logic carry_reg;
   logic carry_next;
   logic int_reset_reg;
   logic done_reg;
   logic port_bad_reg;
   logic blk_rst;
   logic take_op;
   logic fire;
   logic zero_reset;
   logic slot_ok;
   logic [2:0] slot_num;
   alu_op_e eff_op;
   alu_kind_e kind;
   alu_nib_t operand;
   alu_nib_t logic_result;
   logic logic_carry;
   alu_nib_t pin_meta_reg [`ALU_SLOTS];
   alu_nib_t pin_sync_reg [`ALU_SLOTS];
   alu_nib_t latch_reg [`ALU_SLOTS];

   // Controller reset from the zero rotate clears this block too, except the pin synchronisers
   assign blk_rst = i_sys_rst | int_reset_reg;

   // ---------------------------------------------------------------
   // Operand address
   // ---------------------------------------------------------------

   // [RULE3] Page over pointer pair
   assign o_rom_addr = {i_page_ctrl, i_pair_r1, i_pair_r0};

   // ---------------------------------------------------------------
   // Port pin synchronisers and latches
   // ---------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < `ALU_SLOTS; gi = gi + 1) begin : g_slot
         // Pins move freely, so two stages before any mux sees them
         always_ff @(posedge i_core_clk) begin
            if (i_sys_rst) begin
               pin_meta_reg[gi] <= `ALU_LATCH_RST;
               pin_sync_reg[gi] <= `ALU_LATCH_RST;
            end else begin
               pin_meta_reg[gi] <= i_port_pins[gi*4 +: 4];
               pin_sync_reg[gi] <= pin_meta_reg[gi];
            end
         end

         // [RULE15] Latch accumulator out
         always_ff @(posedge i_core_clk) begin
            if (blk_rst) begin
               latch_reg[gi] <= `ALU_LATCH_RST;
            end else if (fire && eff_op == ALU_OP_PORT_WR && slot_ok &&
                         slot_num == 3'(gi)) begin
               latch_reg[gi] <= acc_reg;
            end
         end

         assign o_port_latch[gi*4 +: 4] = latch_reg[gi];
      end
   endgenerate

   // ---------------------------------------------------------------
   // Sequencing
   // ---------------------------------------------------------------
   assign take_op = (state_reg == ALU_ST_IDLE) && i_op_valid &&
      (i_op != ALU_OP_NONE) && !int_reset_reg;
   assign eff_op = (state_reg == ALU_ST_IMM) ? pend_op_reg : i_op;

   // [RULE5] Immediate waits for word
   always_comb begin
      state_next = state_reg;
      fire = 1'b0;
      unique case (state_reg)
         ALU_ST_IDLE: begin
            if (take_op && is_imm(i_op)) begin
               state_next = ALU_ST_IMM;
            end else if (take_op) begin
               fire = 1'b1;
            end
         end
         ALU_ST_IMM: begin
            if (i_word_valid) begin
               fire = 1'b1;
               state_next = ALU_ST_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge i_core_clk) begin
      if (blk_rst) begin
         state_reg <= ALU_ST_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (blk_rst) begin
         pend_op_reg <= ALU_OP_NONE;
      end else if (take_op) begin
         pend_op_reg <= i_op;
      end
   end

   assign o_ready = (state_reg == ALU_ST_IDLE) && !int_reset_reg;

   // ---------------------------------------------------------------
   // Operand and function select
   // ---------------------------------------------------------------
   assign {slot_ok, slot_num} = port_slot(i_port_grp, i_port_idx);

   always_comb begin
      operand = `ALU_ZERO_NIB;
      kind = ALU_K_HOLD;
      unique case (eff_op)
         ALU_OP_AND_REG, ALU_OP_OR_REG, ALU_OP_XOR_REG: begin
            operand = i_reg_data;
         end
         // [RULE2] ROM nibble operand
         ALU_OP_AND_ROM, ALU_OP_OR_ROM, ALU_OP_XOR_ROM: begin
            operand = rom_nib(i_rom_word, i_nib_high);
         end
         // [RULE11] Low data bits
         ALU_OP_AND_IMM, ALU_OP_OR_IMM, ALU_OP_XOR_IMM: begin
            operand = i_word[`ALU_IMM_MSB:`ALU_IMM_LSB];
         end
         // [RULE16] Synchronised port nibble
         ALU_OP_PORT_RD: begin
            operand = pin_sync_reg[slot_num];
         end
         default: begin
            operand = `ALU_ZERO_NIB;
         end
      endcase
      unique case (eff_op)
         ALU_OP_AND_REG, ALU_OP_AND_ROM, ALU_OP_AND_IMM: begin
            kind = ALU_K_AND;
         end
         // [RULE7] Or forms clear carry
         // [RULE8] Immediate uses or
         ALU_OP_OR_REG, ALU_OP_OR_ROM, ALU_OP_OR_IMM: begin
            kind = ALU_K_OR;
         end
         // [RULE10] Xor with nibble
         ALU_OP_XOR_REG, ALU_OP_XOR_ROM, ALU_OP_XOR_IMM: begin
            kind = ALU_K_XOR;
         end
         ALU_OP_INC: begin
            kind = ALU_K_INC;
         end
         ALU_OP_ROT, ALU_OP_ROT_ZRST: begin
            kind = ALU_K_ROT;
         end
         ALU_OP_PORT_RD: begin
            kind = slot_ok ? ALU_K_PASS : ALU_K_HOLD;
         end
         default: begin
            kind = ALU_K_HOLD;
         end
      endcase
   end

   alu_logic u_logic (
      .i_kind(kind),
      .i_acc(acc_reg),
      .i_operand(operand),
      .i_carry(carry_reg),
      .o_result(logic_result),
      .o_carry(logic_carry)
   );

   // [RULE14] Zero test before rotate
   assign zero_reset = fire && (eff_op == ALU_OP_ROT_ZRST) &&
      (acc_reg == `ALU_ZERO_NIB);

   // ---------------------------------------------------------------
   // Accumulator and carry
   // ---------------------------------------------------------------
   always_comb begin
      acc_next = acc_reg;
      carry_next = carry_reg;
      if (fire && !zero_reset) begin
         acc_next = logic_result;
         carry_next = logic_carry;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (blk_rst) begin
         acc_reg <= `ALU_ACC_RST;
      end else begin
         acc_reg <= acc_next;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (blk_rst) begin
         carry_reg <= `ALU_CARRY_RST;
      end else begin
         carry_reg <= carry_next;
      end
   end

   assign o_acc = acc_reg;
   assign o_carry = carry_reg;

   // ---------------------------------------------------------------
   // Status pulses
   // ---------------------------------------------------------------

   // [RULE14] One-cycle reset pulse
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         int_reset_reg <= 1'b0;
      end else begin
         int_reset_reg <= zero_reset;
      end
   end

   // Every operation retires one cycle after it fires
   always_ff @(posedge i_core_clk) begin
      if (blk_rst) begin
         done_reg <= 1'b0;
      end else begin
         done_reg <= fire;
      end
   end

   // Bad index is dropped, not trapped; o_port_bad pulses one cycle after it fires
   always_ff @(posedge i_core_clk) begin
      if (blk_rst) begin
         port_bad_reg <= 1'b0;
      end else begin
         port_bad_reg <= fire && !slot_ok &&
            (eff_op == ALU_OP_PORT_WR || eff_op == ALU_OP_PORT_RD);
      end
   end

   assign o_int_reset = int_reset_reg;
   assign o_done = done_reg;
   assign o_port_bad = port_bad_reg;

endmodule : alu_core

/* sim/alu_core_properties.sv */
`timescale 1ns/10ps
`include "alu_params.svh"

module alu_core_checker
   import alu_pkg::*;
(
   input wire logic i_core_clk, // Core clock
   input wire logic i_sys_rst, // Sync reset
   input wire logic i_op_valid, // Op offered
   input wire alu_op_e i_op, // Op code
   input wire alu_nib_t i_reg_data, // Register operand
   input wire logic [`ALU_PAGE_W-1:0] i_page_ctrl, // ROM page
   input wire alu_nib_t i_pair_r1, // Pointer high
   input wire alu_nib_t i_pair_r0, // Pointer low
   input wire logic [2:0] i_port_idx, // Port index
   input wire logic o_ready, // Ready
   input wire logic [`ALU_ADDR_W-1:0] o_rom_addr, // ROM address
   input wire alu_nib_t o_acc, // Accumulator
   input wire logic o_carry, // Carry
   input wire logic o_int_reset, // Internal reset
   input wire logic [`ALU_PINS_W-1:0] o_port_latch, // Latches
   input wire logic o_port_bad, // Bad index
   input wire logic o_done // Done
);
   // ------------------------------------------------------------
   // Helper state
   // ------------------------------------------------------------
   logic fire;
   logic p_fire;
   alu_op_e p_op;
   alu_nib_t p_acc;
   alu_nib_t p_reg;

   assign fire = o_ready && i_op_valid && (i_op != ALU_OP_NONE);
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         p_fire <= 1'b0;
      end else begin
         p_fire <= fire;
      end
   end
   // No reset: only read when p_fire qualifies it
   always_ff @(posedge i_core_clk) begin
      p_op <= i_op;
      p_acc <= o_acc;
      p_reg <= i_reg_data;
   end

   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_sys_rst);

   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   chk_rom_addr: assert property (
      o_rom_addr == {i_page_ctrl, i_pair_r1, i_pair_r0})
      else $error("rom address not page and pointer");
   chk_one_cycle: assert property (
      p_fire && !(p_op inside {ALU_OP_AND_IMM, ALU_OP_OR_IMM,
      ALU_OP_XOR_IMM}) |-> o_done) else $error("done pulse missing");
   chk_imm_wait: assert property (
      fire && (i_op inside {ALU_OP_AND_IMM, ALU_OP_OR_IMM,
      ALU_OP_XOR_IMM}) |=> !o_ready) else $error("no wait for word");
   chk_and_reg: assert property (
      p_fire && p_op == ALU_OP_AND_REG |-> o_acc == (p_acc & p_reg)
      && o_carry == (p_acc[3] & p_reg[3])) else $error("and wrong");
   chk_or_reg: assert property (
      p_fire && p_op == ALU_OP_OR_REG |-> o_acc == (p_acc | p_reg)
      && !o_carry) else $error("or wrong");
   chk_xor_reg: assert property (
      p_fire && p_op == ALU_OP_XOR_REG |-> o_acc == (p_acc ^ p_reg)
      && o_carry == (p_acc[3] & p_reg[3])) else $error("xor wrong");
   chk_inc_wrap: assert property (
      p_fire && p_op == ALU_OP_INC |-> o_acc == p_acc + 4'h1
      && o_carry == (p_acc == 4'hf)) else $error("increment wrong");
   chk_rotate_left: assert property (
      p_fire && (p_op == ALU_OP_ROT || (p_op == ALU_OP_ROT_ZRST &&
      p_acc != 4'h0)) |-> o_acc == {p_acc[2:0], p_acc[3]} &&
      o_carry == p_acc[3] && !o_int_reset) else $error("rotate wrong");
   chk_zero_reset: assert property (
      fire && i_op == ALU_OP_ROT_ZRST && o_acc == 4'h0 |=> o_int_reset
      ##1 (o_acc == 4'h0 && !o_carry && o_port_latch == 32'h0000_0000))
      else $error("zero rotate did not reset");
   chk_port_bad: assert property (
      fire && i_op == ALU_OP_PORT_WR && !(i_port_idx inside {3'h0, 3'h1,
      3'h3, 3'h4}) |=> o_port_bad && $stable(o_port_latch))
      else $error("bad port index accepted");

   cov_wrap: cover property (p_fire && p_op == ALU_OP_INC && p_acc == 4'hf);
   cov_reset: cover property (o_int_reset);
   cov_bad: cover property (o_port_bad);
   cov_imm: cover property (fire && i_op == ALU_OP_AND_IMM);

endmodule : alu_core_checker

bind alu_core alu_core_checker alu_core_checker_i (.i_core_clk, .i_sys_rst,
   .i_op_valid, .i_op, .i_reg_data, .i_page_ctrl, .i_pair_r1, .i_pair_r0,
   .i_port_idx, .o_ready, .o_rom_addr, .o_acc, .o_carry, .o_int_reset,
   .o_port_latch, .o_port_bad, .o_done);

/* sim/accumulator_logic_unit_tb.sv */
`timescale 1ns/10ps
`include "alu_params.svh"

module accumulator_logic_unit_tb;
   import alu_pkg::*;
   logic i_core_clk = 1'b0;
   logic i_sys_rst = 1'b1;
   logic i_op_valid = 1'b0;
   alu_op_e i_op = ALU_OP_NONE;
   logic i_nib_high = 1'b0;
   alu_nib_t i_reg_data = 4'h0;
   logic i_word_valid = 1'b0;
   logic [9:0] i_word = 10'h000;
   logic [9:0] i_rom_word;
   logic [1:0] i_page_ctrl = 2'h0;
   alu_nib_t i_pair_r1 = 4'h0;
   alu_nib_t i_pair_r0 = 4'h0;
   logic i_port_grp = 1'b0;
   logic [2:0] i_port_idx = 3'h0;
   logic [31:0] i_port_pins = 32'h9c3e_5a71;
   logic o_ready;
   logic [9:0] o_rom_addr;
   alu_nib_t o_acc;
   logic o_carry;
   logic o_int_reset;
   logic [31:0] o_port_latch;
   logic o_port_bad;
   logic o_done;
   int errors = 0;
   int cmp_count = 0;
   int cycles = 0;
   logic [7:0] rnd = 8'h3a;
   alu_nib_t m_acc = 4'h0;
   logic m_carry = 1'b0;
   logic [38:0] seen_w;
   logic [31:0] m_lat = 32'h0000_0000;
   logic [38:0] exp_q[$];

   alu_core alu_core_i (.i_core_clk, .i_sys_rst, .i_op_valid, .i_op,
      .i_nib_high, .i_reg_data, .i_word_valid, .i_word, .i_rom_word,
      .i_page_ctrl, .i_pair_r1, .i_pair_r0, .i_port_grp, .i_port_idx,
      .i_port_pins, .o_ready, .o_rom_addr, .o_acc, .o_carry, .o_int_reset,
      .o_port_latch, .o_port_bad, .o_done);

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic [7:0] lfsr(input logic [7:0] x);
      return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
   endfunction : lfsr

   // Top bits differ from the nibbles so ignoring them is visible
   function automatic logic [9:0] rom_f(input logic [9:0] a);
      return {~a[1:0], a[7:0] ^ 8'ha5};
   endfunction : rom_f

   assign i_rom_word = rom_f(o_rom_addr);
   assign seen_w = {o_acc, o_carry, o_port_latch, o_int_reset, o_port_bad};
   always #50 i_core_clk = ~i_core_clk;

   task automatic check(input logic [38:0] seen, input logic [38:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic summarize();
      $display("counts: %0d compares, %0d mismatches", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : summarize

   // One operation; the reference note is queued when it fires
   task automatic run(input alu_op_e op, input alu_nib_t rd,
         input logic [9:0] w = 10'h3f5, input logic hi = 1'b0,
         input logic [2:0] idx = 3'h0, input logic grp = 1'b0);
      logic [9:0] rw;
      alu_nib_t opd;
      logic [2:0] slot;
      logic bad;
      logic irst;
      logic imm;
      rnd = lfsr(rnd);
      rw = rom_f({rnd[1:0], rnd});
      i_page_ctrl <= rnd[1:0];
      i_pair_r1 <= rnd[7:4];
      i_pair_r0 <= rnd[3:0];
      i_op_valid <= 1'b1;
      i_op <= op;
      i_reg_data <= rd;
      i_nib_high <= hi;
      i_port_idx <= idx;
      i_port_grp <= grp;
      do @(posedge i_core_clk); while (o_ready !== 1'b1);
      imm = op inside {ALU_OP_AND_IMM, ALU_OP_OR_IMM, ALU_OP_XOR_IMM};
      if (imm) begin
         i_op_valid <= 1'b0;
         i_word_valid <= 1'b1;
         i_word <= w;
         @(posedge i_core_clk);
         i_word_valid <= 1'b0;
      end
      opd = imm ? w[3:0] : rd;
      if (op inside {ALU_OP_AND_ROM, ALU_OP_OR_ROM, ALU_OP_XOR_ROM})
         opd = hi ? rw[7:4] : rw[3:0];
      bad = (op inside {ALU_OP_PORT_WR, ALU_OP_PORT_RD}) &&
         !(idx inside {3'h0, 3'h1, 3'h3, 3'h4});
      slot = {grp, (idx == 3'h4) ? 2'h3 : (idx == 3'h3) ? 2'h2 : idx[1:0]};
      irst = (op == ALU_OP_ROT_ZRST) && (m_acc == 4'h0);
      case (op)
         ALU_OP_AND_REG, ALU_OP_AND_ROM, ALU_OP_AND_IMM: begin
            m_carry = m_acc[3] & opd[3];
            m_acc = m_acc & opd;
         end
         ALU_OP_OR_REG, ALU_OP_OR_ROM, ALU_OP_OR_IMM: begin
            m_acc = m_acc | opd;
            m_carry = 1'b0;
         end
         ALU_OP_XOR_REG, ALU_OP_XOR_ROM, ALU_OP_XOR_IMM: begin
            m_carry = m_acc[3] & opd[3];
            m_acc = m_acc ^ opd;
         end
         ALU_OP_INC: begin
            m_acc = m_acc + 4'h1;
            m_carry = (m_acc == 4'h0);
         end
         ALU_OP_ROT, ALU_OP_ROT_ZRST: if (!irst) begin
            m_carry = m_acc[3];
            m_acc = {m_acc[2:0], m_acc[3]};
         end
         ALU_OP_PORT_WR: if (!bad) m_lat[{slot, 2'b00} +: 4] = m_acc;
         ALU_OP_PORT_RD: if (!bad) m_acc = i_port_pins[{slot, 2'b00} +: 4];
         default: ;
      endcase
      exp_q.push_back({m_acc, m_carry, m_lat, irst, bad});
      if (irst) begin
         m_acc = 4'h0;
         m_carry = 1'b0;
         m_lat = 32'h0000_0000;
      end
   endtask : run

   // ------------------------------------------------------------
   // Result watcher
   // ------------------------------------------------------------
   always @(posedge i_core_clk) begin
      if (o_done === 1'b1) begin
         if (exp_q.size() == 0)
            check(39'h1, 39'h0);
         else
            check(seen_w, exp_q.pop_front());
      end
   end

   // Hang guard, far above the few hundred cycles needed
   always @(posedge i_core_clk) begin
      cycles++;
      if (cycles == 3000) begin
         errors++;
         summarize();
      end
   end

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (6) @(posedge i_core_clk);
      i_sys_rst <= 1'b0;
      repeat (3) @(posedge i_core_clk);
      $display("test reset done");
      for (int k = 0; k < 90; k++) begin
         rnd = lfsr(rnd);
         run(alu_op_e'(rnd % 8'd14 + 8'd1), rnd[3:0], {rnd[1:0], lfsr(rnd)},
            rnd[4], rnd[7:5], rnd[2]);
      end
      $display("test random done");
      // fifteen wraps, then zero rotate resets
      run(ALU_OP_OR_REG, 4'hf);
      run(ALU_OP_INC, 4'h0);
      run(ALU_OP_ROT_ZRST, 4'h0);
      run(ALU_OP_XOR_IMM, 4'h0, 10'h20b);
      $display("test wrap done");
      i_op_valid <= 1'b0;
      i_port_pins <= 32'h47d2_e18b;
      repeat (3) @(posedge i_core_clk);
      for (int i = 0; i < 16; i++) begin
         run(ALU_OP_XOR_REG, i[3:0]);
         run(ALU_OP_PORT_WR, 4'h0, 10'h000, 1'b0, i[2:0], i[3]);
         run(ALU_OP_PORT_RD, 4'h0, 10'h000, 1'b0, i[2:0], i[3]);
      end
      i_op_valid <= 1'b0;
      repeat (3) @(posedge i_core_clk);
      check(39'(exp_q.size()), 39'h0);
      $display("test ports done");
      summarize();
   end

endmodule : accumulator_logic_unit_tb
